// [src/fhc_regs.vh]
// Constants for the floppy host command port block
// Operation
// - Byte command is one write; high nibble command, low nibble pointer or mask.
// - Byte command 0 starts the string addressed by pointer in low nibble.
// - Started string is fetched from host memory by DMA, then executed.
// - Byte command 1 takes next two writes, low then high, as pointer.
// - Byte command 2 restores every selected drive to track 0.
// - Byte command 3 sets software write protect on selected drives.
// - All software write protect flags clear after power-on.
// - Byte command 4 clears software write protect on selected drives.
// - Byte commands 5 to 15 only clear a pending interrupt.
// - Reset loads pointer 0 with 0080, pointer n with n000.
// - For commands 2,3,4 bit k of low nibble selects drive k.
// - Drive command with all-zero mask does nothing.
// - Command string is 4 to 9 bytes, length set by its command.
// - First string byte: high digit disk command, low digit drive mask.
// - Completion writes non-zero status; bit 7 failure, success only bit 0.
// - Bytes 3 and 4 carry track; byte 3 zero, byte 4 0 to 76.
// - Bytes 3-4 give physical track; also logical unless separate given.
// - Bytes 5 to 9 are interpreted per the disk command number.
// - Non-zero status at start reports error 0x41.
// - String selecting no drive reports error 0x42.
`ifndef FHC_REGS_VH
`define FHC_REGS_VH
`define FHC_BC_EXEC      4'h0
`define FHC_BC_LOADPTR   4'h1
`define FHC_BC_RESTORE   4'h2
`define FHC_BC_WPSET     4'h3
`define FHC_BC_WPCLR     4'h4
`define FHC_PTR0_RESET   16'h0080
`define FHC_ST_OK        8'h01
`define FHC_ST_NZSTAT    8'h41
`define FHC_ST_NODRV     8'h42
`define FHC_ST_MULTDRV   8'h43
`define FHC_ST_BADCMD    8'h44
`define FHC_ST_BADTRK    8'h45
`define FHC_ST_BADLTRK   8'h48
`define FHC_TRK_MAX      8'h4C
`define FHC_CS_STATUS    16'h0001
`endif

// [src/fhc_len.v]
// Command string length lookup by disk command number
`timescale 1ns/1ps
`default_nettype none
module fhc_len (
    input  wire [3:0] cmd,
    output reg  [3:0] len,
    output reg        legal,
    output reg        has_ltrk
);
    // Base lengths for commands 0-5, logical track adds two for 7-11
    always @* begin
        legal    = 1'b1;
        has_ltrk = 1'b0;
        case (cmd)
            4'h0: len = 4'h5;
            4'h1: len = 4'h7;
            4'h2: len = 4'h7;
            4'h3: len = 4'h4;
            4'h4: len = 4'h5;
            4'h5: len = 4'h5;
            4'h7: begin len = 4'h9; has_ltrk = 1'b1; end
            4'h8: begin len = 4'h9; has_ltrk = 1'b1; end
            4'h9: begin len = 4'h6; has_ltrk = 1'b1; end
            4'hA: begin len = 4'h7; has_ltrk = 1'b1; end
            4'hB: begin len = 4'h7; has_ltrk = 1'b1; end
            default: begin len = 4'h4; legal = 1'b0; end
        endcase
    end
endmodule // fhc_len
`default_nettype wire

// [src/fhc_port.v]
// Host command port interpreter with command string DMA fetch
`timescale 1ns/1ps
`default_nettype none
`include "fhc_regs.vh"
module fhc_port #(
    parameter NDRV = 4
) (
    input  wire        clk_sys,
    input  wire        arst_n,
    input  wire [7:0]  host_command_port,
    input  wire        port_wr,
    output wire        port_busy,
    output reg         dma_req,
    output reg         dma_we,
    output reg  [15:0] dma_addr,
    output reg  [7:0]  dma_wdata,
    input  wire        dma_ack,
    input  wire [7:0]  dma_rdata,
    output reg         restore_go,
    output reg  [3:0]  restore_mask,
    output reg  [3:0]  wprot,
    output reg         irq,
    input  wire        irq_set,
    output reg         disk_go,
    output reg  [3:0]  disk_cmd,
    output reg  [3:0]  disk_drive,
    output reg  [7:0]  disk_track,
    output reg  [7:0]  disk_ltrack,
    output reg  [39:0] disk_args,
    input  wire        disk_done,
    input  wire [7:0]  disk_status
);
    localparam S_IDLE  = 3'd0;
    localparam S_FETCH = 3'd1;
    localparam S_CHECK = 3'd2;
    localparam S_DISK  = 3'd3;
    localparam S_WRST  = 3'd4;

    reg [15:0] ptr [0:15];
    reg [2:0]  state;
    reg [1:0]  load_phase;
    reg [3:0]  load_idx;
    reg [7:0]  load_lo;
    reg [15:0] base;
    reg [3:0]  idx;
    reg [7:0]  cs [0:8];
    reg [7:0]  st_out;
    wire [3:0] len;
    wire       legal;
    wire       has_ltrk;
    wire [3:0] opc = host_command_port[7:4];
    wire [3:0] arg = host_command_port[3:0];
    integer    i;

    fhc_len u_len (
        .cmd      (cs[0][7:4]),
        .len      (len),
        .legal    (legal),
        .has_ltrk (has_ltrk)
    );

    // Port is refused while a string runs, so exec cannot be lost
    assign port_busy = (state != S_IDLE);

    // Pointer table, reset defaults, two-byte load
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_ptr
            always @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) begin
                    ptr[g] <= (g == 0) ? `FHC_PTR0_RESET
                                       : {g[3:0], 12'h000};
                end else if (port_wr && load_phase == 2'd2 &&
                             load_idx == g[3:0]) begin
                    ptr[g] <= {host_command_port, load_lo};
                end
            end
        end
    endgenerate

    // Byte command decode
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            load_phase   <= 2'd0;
            load_idx     <= 4'h0;
            load_lo      <= 8'h00;
            restore_go   <= 1'b0;
            restore_mask <= 4'h0;
            wprot        <= 4'h0;
            irq          <= 1'b0;
        end else begin
            restore_go <= 1'b0;
            if (irq_set)
                irq <= 1'b1;
            if (port_wr && load_phase == 2'd1) begin
                load_lo    <= host_command_port;
                load_phase <= 2'd2;
            end else if (port_wr && load_phase == 2'd2) begin
                load_phase <= 2'd0;
            end else if (port_wr && state == S_IDLE) begin
                case (opc)
                    `FHC_BC_EXEC: ;
                    `FHC_BC_LOADPTR: begin
                        load_idx   <= arg;
                        load_phase <= 2'd1;
                    end
                    `FHC_BC_RESTORE: begin
                        restore_go   <= |arg;
                        restore_mask <= arg;
                    end
                    `FHC_BC_WPSET: wprot <= wprot | arg;
                    `FHC_BC_WPCLR: wprot <= wprot & ~arg;
                    default: begin
                        if (!irq_set)
                            irq <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Command string engine
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state       <= S_IDLE;
            base        <= 16'h0000;
            idx         <= 4'h0;
            dma_req     <= 1'b0;
            dma_we      <= 1'b0;
            dma_addr    <= 16'h0000;
            dma_wdata   <= 8'h00;
            st_out      <= 8'h00;
            disk_go     <= 1'b0;
            disk_cmd    <= 4'h0;
            disk_drive  <= 4'h0;
            disk_track  <= 8'h00;
            disk_ltrack <= 8'h00;
            disk_args   <= 40'h0;
            for (i = 0; i < 9; i = i + 1)
                cs[i] <= 8'h00;
        end else begin
            disk_go <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (port_wr && load_phase == 2'd0 &&
                        opc == `FHC_BC_EXEC) begin
                        base     <= ptr[arg];
                        dma_addr <= ptr[arg];
                        dma_req  <= 1'b1;
                        dma_we   <= 1'b0;
                        idx      <= 4'h0;
                        state    <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    if (dma_ack) begin
                        cs[idx] <= dma_rdata;
                        // length from first byte once known
                        if (idx >= 4'd3 && (idx + 4'd1) >=
                            ((idx == 4'd0) ? 4'd4 : len)) begin
                            dma_req <= 1'b0;
                            state   <= S_CHECK;
                        end else begin
                            idx      <= idx + 4'd1;
                            dma_addr <= dma_addr + 16'h0001;
                        end
                    end
                end
                S_CHECK: begin
                    disk_cmd    <= cs[0][7:4];
                    disk_drive  <= cs[0][3:0];
                    disk_track  <= cs[3];
                    disk_ltrack <= has_ltrk ? cs[len - 4'd1] : cs[3];
                    disk_args   <= {cs[8], cs[7], cs[6], cs[5], cs[4]};
                    state       <= S_WRST;
                    if (cs[1] != 8'h00)
                        st_out <= `FHC_ST_NZSTAT;
                    else if (cs[0][3:0] == 4'h0)
                        st_out <= `FHC_ST_NODRV;
                    else if ((cs[0][3:0] & (cs[0][3:0] - 4'h1)) != 4'h0)
                        st_out <= `FHC_ST_MULTDRV;
                    else if (!legal)
                        st_out <= `FHC_ST_BADCMD;
                    else if (cs[2] != 8'h00 || cs[3] > `FHC_TRK_MAX)
                        st_out <= `FHC_ST_BADTRK;
                    else if (has_ltrk && (cs[len - 4'd2] != 8'h00 ||
                             cs[len - 4'd1] > `FHC_TRK_MAX))
                        st_out <= `FHC_ST_BADLTRK;
                    else begin
                        disk_go <= 1'b1;
                        state   <= S_DISK;
                    end
                end
                S_DISK: begin
                    if (disk_done) begin
                        // anything but plain success is marked failed
                        st_out <= (disk_status == `FHC_ST_OK)
                                  ? `FHC_ST_OK : (disk_status | 8'h80);
                        state  <= S_WRST;
                    end
                end
                S_WRST: begin
                    if (!dma_req) begin
                        dma_req   <= 1'b1;
                        dma_we    <= 1'b1;
                        dma_addr  <= base + `FHC_CS_STATUS;
                        dma_wdata <= (st_out[6]) ? (st_out | 8'h80) : st_out;
                    end else if (dma_ack) begin
                        dma_req <= 1'b0;
                        dma_we  <= 1'b0;
                        state   <= S_IDLE;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule // fhc_port
`default_nettype wire

// [verif/fhc_port_asserts.sv]
// Property checker watching the host command port
`timescale 1ns/1ps
`default_nettype none
module fhc_port_asserts (
    input wire logic        clk_sys, arst_n, port_wr, port_busy,
    input wire logic        dma_req, dma_we, dma_ack, restore_go,
    input wire logic        irq, irq_set, disk_done,
    input wire logic [7:0]  host_command_port, dma_wdata, disk_status,
    input wire logic [15:0] dma_addr,
    input wire logic [3:0]  restore_mask, wprot
);
    // Byte command fields, taken only while idle
    logic [3:0] cmd, msk;
    logic       take;
    logic [1:0] load_ph;
    // Pointer-load bytes are data, not commands; follow the load sequence
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            load_ph <= 2'd0;
        else if (port_wr && load_ph != 2'd0)
            load_ph <= (load_ph == 2'd1) ? 2'd2 : 2'd0;
        else if (port_wr && !port_busy && host_command_port[7:4] == 4'h1)
            load_ph <= 2'd1;
    end
    assign cmd  = host_command_port[7:4];
    assign msk  = host_command_port[3:0];
    assign take = port_wr && !port_busy && load_ph == 2'd0;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    property p_restore;
        take && cmd == 4'h2 && msk != 4'h0 |=>
            restore_go && restore_mask == $past(msk);
    endproperty
    a_restore: assert property (p_restore) else $error("restore");
    property p_nomask;
        take && cmd inside {4'h2, 4'h3, 4'h4} && msk == 4'h0 |=>
            !restore_go && $stable(wprot);
    endproperty
    a_nomask: assert property (p_nomask) else $error("empty mask");
    property p_wpset;
        take && cmd == 4'h3 |=> wprot == ($past(wprot) | $past(msk));
    endproperty
    a_wpset: assert property (p_wpset) else $error("protect set");
    property p_wpclr;
        take && cmd == 4'h4 |=> wprot == ($past(wprot) & ~$past(msk));
    endproperty
    a_wpclr: assert property (p_wpclr) else $error("protect clear");
    property p_rst;
        !$past(arst_n) |-> wprot == 4'h0 && !dma_req;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_exec;
        take && cmd == 4'h0 |=> dma_req && !dma_we;
    endproperty
    a_exec: assert property (p_exec) else $error("no fetch");
    property p_quiet;
        take && cmd >= 4'h5 && !irq_set |=>
            !irq && !restore_go && $stable(wprot);
    endproperty
    a_quiet: assert property (p_quiet) else $error("no-op acted");
    property p_hold;
        dma_req && !dma_ack |=> dma_req && $stable(dma_addr) && $stable(dma_we);
    endproperty
    a_hold: assert property (p_hold) else $error("dma dropped");
    property p_ok;
        disk_done && disk_status == 8'h01 |->
            ##[1:8] dma_req && dma_we && dma_wdata == 8'h01;
    endproperty
    a_ok: assert property (p_ok) else $error("status");
    c_exec: cover property (take && cmd == 4'h0);
    c_restore: cover property (restore_go);
    c_stat: cover property (dma_req && dma_we && dma_ack);
endmodule // fhc_port_asserts
bind fhc_port fhc_port_asserts u_chk (.clk_sys, .arst_n, .port_wr,
    .port_busy, .dma_req, .dma_we, .dma_ack, .restore_go, .irq, .irq_set,
    .disk_done, .host_command_port, .dma_wdata, .disk_status, .dma_addr,
    .restore_mask, .wprot);
`default_nettype wire

// [verif/fhc_mem.sv]
// Host main memory answering the block's DMA requests
`timescale 1ns/1ps
`default_nettype none
module fhc_mem (
    input wire logic        clk_sys, arst_n, dma_req, dma_we, slow,
    input wire logic [15:0] dma_addr,
    input wire logic [7:0]  dma_wdata,
    output logic            dma_ack,
    output logic [7:0]      dma_rdata
);
    logic [7:0] mem [0:65535];
    logic [1:0] cnt;
    // one byte per ack; slow mode waits, data toggles when not valid
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dma_ack <= 1'b0;
            dma_rdata <= 8'h00;
            cnt <= 2'h0;
        end else begin
            dma_ack <= 1'b0;
            dma_rdata <= ~dma_rdata;
            if (dma_req && !dma_ack) begin
                if (slow && cnt != 2'h3) begin
                    cnt <= cnt + 2'h1;
                end else begin
                    cnt <= 2'h0;
                    dma_ack <= 1'b1;
                    if (dma_we) mem[dma_addr] <= dma_wdata;
                    else dma_rdata <= mem[dma_addr];
                end
            end
        end
    end
endmodule // fhc_mem
`default_nettype wire

// [verif/floppy_host_command_port_tb.sv]
// Testbench for the host command port
`timescale 1ns/1ps
`default_nettype none
module floppy_host_command_port_tb;
    logic clk_sys = 0, arst_n = 0, port_wr = 0, irq_set = 0, mem_slow = 0;
    logic disk_done = 0;
    logic [7:0] host_command_port = 0, disk_status = 0, dstat = 8'h01;
    wire port_busy, dma_req, dma_we, dma_ack, restore_go, irq, disk_go;
    wire [15:0] dma_addr;
    wire [7:0] dma_wdata, dma_rdata, disk_track, disk_ltrack;
    wire [3:0] restore_mask, wprot, disk_cmd, disk_drive;
    wire [39:0] disk_args;
    int n_fail = 0, total_checks = 0, cyc = 0, k;
    always #5 clk_sys = ~clk_sys;
    fhc_port DUT (.clk_sys, .arst_n, .host_command_port, .port_wr,
        .port_busy, .dma_req, .dma_we, .dma_addr, .dma_wdata, .dma_ack,
        .dma_rdata, .restore_go, .restore_mask, .wprot, .irq, .irq_set,
        .disk_go, .disk_cmd, .disk_drive, .disk_track, .disk_ltrack,
        .disk_args, .disk_done, .disk_status);
    fhc_mem u_mem (.clk_sys, .arst_n, .dma_req, .dma_we, .slow(mem_slow),
        .dma_addr, .dma_wdata, .dma_ack, .dma_rdata);
    // Disk side finishes one cycle after each start
    always @(posedge clk_sys) begin
        disk_done <= disk_go;
        disk_status <= dstat;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            close_out;
        end
    end
    task close_out;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(input string nm, input logic [23:0] got, input logic [23:0] e);
        total_checks++;
        if (got !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, got);
        end
    endtask
    task wr(input logic [7:0] b);
        @(posedge clk_sys);
        port_wr <= 1'b1;
        host_command_port <= b;
    endtask
    // Drop the strobe after the taking edge, then settle
    task idle;
        @(posedge clk_sys);
        port_wr <= 1'b0;
        #1;
    endtask
    task run(input logic [3:0] p, input logic [15:0] a,
             input logic [63:0] s, input logic [7:0] e);
        int i;
        // status byte comes from the string image
        for (i = 0; i < 8; i++) u_mem.mem[a + i] = s[8*i +: 8];
        wr({4'h0, p});
        idle;
        chk("busy", port_busy, 24'h1);
        for (i = 0; i < 400 && u_mem.mem[a + 1] === s[15:8]; i++)
            @(posedge clk_sys);
        chk("status", u_mem.mem[a + 1], e);
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        #1;
        chk("wprot", wprot, 24'h0);
        run(4'h0, 16'h0080, 64'h05000031, 8'h01);
        chk("disk", {disk_cmd, disk_drive, disk_track}, 24'h3105);
        mem_slow <= 1'b1;
        wr(8'h15);
        wr(8'h00);
        wr(8'h20);
        idle;
        run(4'h5, 16'h2000, 64'h4000030A000024, 8'h01);
        chk("args", disk_args[23:0], 24'h400003);
        chk("track", {disk_drive, disk_track}, 24'h40A);
        run(4'h1, 16'h1000, 64'h05000731, 8'hC1);
        run(4'h1, 16'h1000, 64'h05000030, 8'hC2);
        run(4'h6, 16'h6000, 64'h070005000092, 8'h01);
        chk("ltrack", {disk_track, disk_ltrack}, 24'h0507);
        run(4'h6, 16'h6000, 64'h500005000092, 8'hC8);
        run(4'h7, 16'h7000, 64'h4D000031, 8'hC5);
        run(4'h8, 16'h8000, 64'h05000033, 8'hC3);
        run(4'h9, 16'h9000, 64'h05000061, 8'hC4);
        dstat <= 8'h12;
        run(4'h3, 16'h3000, 64'h05000031, 8'h92);
        wr(8'h35);
        idle;
        chk("wprot", wprot, 24'h5);
        wr(8'h41);
        idle;
        chk("wprot", wprot, 24'h4);
        wr(8'h30);
        idle;
        chk("wprot", wprot, 24'h4);
        wr(8'h26);
        idle;
        chk("restore", {restore_go, restore_mask}, 24'h16);
        // every no-op command clears a pending interrupt
        for (k = 5; k < 16; k++) begin
            @(posedge clk_sys);
            irq_set <= 1'b1;
            wr({k[3:0], 4'hF});
            irq_set <= 1'b0;
            #1;
            chk("irq", irq, 24'h1);
            idle;
            chk("irq", {irq, wprot}, 24'h04);
        end
        close_out;
    end
endmodule // floppy_host_command_port_tb
`default_nettype wire
